// >>> pkg/tcm_map.svh
`ifndef TCM_MAP_SVH
`define TCM_MAP_SVH
// APB byte offsets
`define TCM_OFF_CTRL 12'h000
`define TCM_OFF_COUNT 12'h004
`define TCM_OFF_CMP 12'h008
`define TCM_OFF_FORCE 12'h00c
`define TCM_OFF_STATUS 12'h010
`define TCM_OFF_MASK 12'h014
`define TCM_OFF_PORT 12'h018
// Control field positions
`define TCM_CTRL_COM_LSB 0
`define TCM_CTRL_WGM_LSB 4
`define TCM_CTRL_EN_BIT 8
// Status bits
`define TCM_ST_OVF_BIT 0
`define TCM_ST_CMP_BIT 1
// Reset values and counter top
`define TCM_RST_CTRL 32'h0000_0000
`define TCM_RST_CMP 16'hffff
`define TCM_MAX_COUNT 16'hffff
`define TCM_BOTTOM 16'h0000
`endif

// >>> pkg/tcm_pkg.sv
package tcm_pkg;
  typedef enum logic [1:0] {
    TCM_COM_OFF = 2'h0,
    TCM_COM_TOGGLE = 2'h1,
    TCM_COM_CLEAR = 2'h2,
    TCM_COM_SET = 2'h3
  } tcm_com_t;
  typedef struct packed {
    logic [3:0] wgm;
    tcm_com_t com;
    logic en;
  } tcm_ctrl_t;
  typedef struct packed {
    logic port_out;
    logic port_dir;
  } tcm_port_t;
  typedef struct packed {
    logic pin_out;
    logic pin_oe_n;
  } tcm_pin_t;
endpackage

// >>> logic/tcm_timer.sv
`timescale 1ns/10ps
`include "tcm_map.svh"
module tcm_timer
  import tcm_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic OVF_ACK_I,
  output logic IRQ_O,
  output logic PIN_OUT_O,
  output logic PIN_OE_N_O
);

  if (CNT_W != 16) begin : g_chk
    $error("tcm_timer supports a 16-bit counter only");
  end

  tcm_ctrl_t ctrl_r;
  tcm_port_t port_r;
  tcm_pin_t pin_nxt;
  logic [15:0] count_r;
  logic [15:0] cmp_r;
  logic [1:0] status_r;
  logic [1:0] mask_r;
  logic oc_r;
  logic block_r;
  logic wr_en;
  logic rd_en;
  logic wr_ctrl;
  logic wr_count;
  logic wr_force;
  logic wr_status;
  logic match;
  logic non_pwm;
  logic oc_nxt;
  logic act;
  logic [1:0] ev_set;

  assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && CE_I;
  assign rd_en = PSEL_I && PENABLE_I && !PWRITE_I;
  assign wr_ctrl = wr_en && (PADDR_I == `TCM_OFF_CTRL);
  assign wr_count = wr_en && (PADDR_I == `TCM_OFF_COUNT);
  assign wr_force = wr_en && (PADDR_I == `TCM_OFF_FORCE) && PWDATA_I[0];
  assign wr_status = wr_en && (PADDR_I == `TCM_OFF_STATUS);
  assign PREADY_O = 1'b1;

  always_comb begin
    PSLVERR_O = 1'b0;
    if (PSEL_I && PENABLE_I) begin
      unique case (PADDR_I)
        `TCM_OFF_CTRL, `TCM_OFF_COUNT, `TCM_OFF_CMP, `TCM_OFF_FORCE,
        `TCM_OFF_STATUS, `TCM_OFF_MASK, `TCM_OFF_PORT: PSLVERR_O = 1'b0;
        default: PSLVERR_O = 1'b1;
      endcase
    end
  end

  // Control and port registers
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      ctrl_r <= tcm_ctrl_t'(`TCM_RST_CTRL);
      cmp_r <= `TCM_RST_CMP;
      mask_r <= 2'h0;
      port_r <= '0;
    end else if (CE_I && wr_en) begin
      unique case (PADDR_I)
        `TCM_OFF_CTRL: begin
          ctrl_r.com <= tcm_com_t'(PWDATA_I[`TCM_CTRL_COM_LSB +: 2]);
          ctrl_r.wgm <= PWDATA_I[`TCM_CTRL_WGM_LSB +: 4];
          ctrl_r.en <= PWDATA_I[`TCM_CTRL_EN_BIT];
        end
        `TCM_OFF_CMP: cmp_r <= PWDATA_I[15:0];
        `TCM_OFF_MASK: mask_r <= PWDATA_I[1:0];
        `TCM_OFF_PORT: port_r <= tcm_port_t'(PWDATA_I[1:0]);
        default: ;
      endcase
    end
  end

  // Only normal mode counting is served, with the enable bit set; mode field alone decides non-PWM
  assign non_pwm = (ctrl_r.wgm == 4'h0) || (ctrl_r.wgm == 4'h4) || (ctrl_r.wgm == 4'hc);
  assign match = ctrl_r.en && !block_r && (count_r == cmp_r);

  // Counter
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      count_r <= `TCM_BOTTOM;
      block_r <= 1'b0;
    end else if (CE_I) begin
      block_r <= wr_count;
      if (wr_count) begin
        count_r <= PWDATA_I[15:0];
      end else if (ctrl_r.en && ctrl_r.wgm == 4'h0) begin
        count_r <= count_r + 16'h0001;
      end
    end
  end

  // Compare output action; com read at match time and on a force write in a non-PWM mode
  always_comb begin
    act = match || (wr_force && non_pwm);
    oc_nxt = oc_r;
    if (act) begin
      unique case (ctrl_r.com)
        TCM_COM_OFF: oc_nxt = oc_r;
        TCM_COM_TOGGLE: oc_nxt = !oc_r;
        TCM_COM_CLEAR: oc_nxt = 1'b0;
        TCM_COM_SET: oc_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      oc_r <= 1'b0;
    end else if (CE_I) begin
      oc_r <= oc_nxt;
    end
  end

  // Event flags, set wins over clear
  assign ev_set[`TCM_ST_OVF_BIT] = CE_I && !wr_count && ctrl_r.en && ctrl_r.wgm == 4'h0
    && count_r == `TCM_MAX_COUNT;
  assign ev_set[`TCM_ST_CMP_BIT] = CE_I && match;

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      status_r <= 2'h0;
    end else if (CE_I) begin
      status_r <= ev_set
        | (status_r & ~(wr_status ? PWDATA_I[1:0] : 2'h0)
        & ~{1'b0, OVF_ACK_I});
    end
  end

  assign IRQ_O = |(status_r & mask_r);

  // Pin mux; com field selects oc or the port output bit, no capture path
  always_comb begin
    pin_nxt.pin_oe_n = !port_r.port_dir;
    if (ctrl_r.com != TCM_COM_OFF) begin
      pin_nxt.pin_out = oc_r;
    end else begin
      pin_nxt.pin_out = port_r.port_out;
    end
  end
  assign PIN_OUT_O = pin_nxt.pin_out;
  assign PIN_OE_N_O = pin_nxt.pin_oe_n;

  always_comb begin
    PRDATA_O = 32'h0000_0000;
    if (rd_en) begin
      unique case (PADDR_I)
        `TCM_OFF_CTRL: PRDATA_O = {23'h0, ctrl_r.en, ctrl_r.wgm, 2'h0, ctrl_r.com};
        `TCM_OFF_COUNT: PRDATA_O = {16'h0, count_r};
        `TCM_OFF_CMP: PRDATA_O = {16'h0, cmp_r};
        `TCM_OFF_FORCE: PRDATA_O = {31'h0, oc_r};
        `TCM_OFF_STATUS: PRDATA_O = {30'h0, status_r};
        `TCM_OFF_MASK: PRDATA_O = {30'h0, mask_r};
        `TCM_OFF_PORT: PRDATA_O = {30'h0, port_r};
        default: PRDATA_O = 32'h0000_0000;
      endcase
    end
  end

  // Assertions
  sequence s_at_max;
    ctrl_r.en && ctrl_r.wgm == 4'h0 && !wr_count && CE_I && count_r == 16'hffff;
  endsequence

  a_wrap_zero: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_at_max |=> count_r == 16'h0000) else $error("counter did not wrap");
  a_ovf_with_zero: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_at_max |=> status_r[0]) else $error("overflow not set at wrap");
  a_ovf_only_set: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    $rose(status_r[0]) |-> $past(count_r) == 16'hffff) else $error("overflow set wrongly");
  a_count_inc: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    ctrl_r.en && ctrl_r.wgm == 4'h0 && CE_I && !wr_count
    |=> count_r == $past(count_r) + 16'h0001) else $error("counter did not increment");
  a_cnt_write: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    wr_count |=> count_r == $past(PWDATA_I[15:0])) else $error("count write lost");
  a_mode_zero_hold: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    CE_I && ctrl_r.com == TCM_COM_OFF |=> oc_r == $past(oc_r)) else $error("oc changed");
  a_toggle_match: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    CE_I && match && ctrl_r.com == TCM_COM_TOGGLE |=> oc_r != $past(oc_r))
    else $error("toggle missed");
  a_force_set: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    wr_force && non_pwm && ctrl_r.com == TCM_COM_SET |=> oc_r) else $error("force failed");
  a_pin_source: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    ctrl_r.com != TCM_COM_OFF |-> PIN_OUT_O == oc_r) else $error("pin not from oc");
  a_pin_port: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    ctrl_r.com == TCM_COM_OFF |-> PIN_OUT_O == port_r.port_out) else $error("pin not port");
  a_pin_dir: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    PIN_OE_N_O == !port_r.port_dir) else $error("direction wrong");
  a_reset_oc: assert property (@(posedge CLOCK_I)
    RST_I |=> !oc_r) else $error("oc not cleared");

  // Counter at bottom while counting
  sequence s_at_zero;
    ctrl_r.en && ctrl_r.wgm == 4'h0 && !wr_count && CE_I && count_r == 16'h0000;
  endsequence

  // Overflow serviced with no new overflow
  sequence s_ack_only;
    CE_I && OVF_ACK_I && !ev_set[`TCM_ST_OVF_BIT];
  endsequence

  a_force_clear: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    wr_force && non_pwm && ctrl_r.com == TCM_COM_CLEAR |=> !oc_r)
    else $error("force clear failed");

  a_force_toggle: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    wr_force && non_pwm && ctrl_r.com == TCM_COM_TOGGLE |=> oc_r != $past(oc_r))
    else $error("force toggle failed");

  a_force_off: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    wr_force && ctrl_r.com == TCM_COM_OFF |=> oc_r == $past(oc_r))
    else $error("force changed oc in mode zero");

  a_match_clear: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    CE_I && match && ctrl_r.com == TCM_COM_CLEAR |=> !oc_r)
    else $error("clear on match missed");

  a_match_set: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    CE_I && match && ctrl_r.com == TCM_COM_SET |=> oc_r)
    else $error("set on match missed");

  a_oc_idle: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    CE_I && !match && !(wr_force && non_pwm) |=> oc_r == $past(oc_r))
    else $error("oc changed without match");

  a_match_blocked: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    block_r |-> !match)
    else $error("match not blocked");

  a_block_after_write: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    wr_count |=> !match)
    else $error("match after count write");

  a_count_freeze: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    !CE_I |=> count_r == $past(count_r))
    else $error("count moved while frozen");

  a_oc_freeze: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    !CE_I |=> oc_r == $past(oc_r))
    else $error("oc moved while frozen");

  a_flag_freeze: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    !CE_I |=> status_r == $past(status_r))
    else $error("flags moved while frozen");

  a_other_mode_hold: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    CE_I && !wr_count && ctrl_r.wgm != 4'h0 |=> count_r == $past(count_r))
    else $error("count moved in unserved mode");

  a_stopped_hold: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    CE_I && !wr_count && !ctrl_r.en |=> count_r == $past(count_r))
    else $error("count moved while stopped");

  a_no_clear_match: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    CE_I && ctrl_r.en && ctrl_r.wgm == 4'h0 && !wr_count && match
    && count_r != 16'hffff |=> count_r != 16'h0000)
    else $error("counter cleared on match");

  a_wrap_restart: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_at_zero |=> count_r == 16'h0001)
    else $error("count did not restart from bottom");

  a_ovf_sticky: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    CE_I && status_r[0] && !OVF_ACK_I && !(wr_status && PWDATA_I[0]) |=> status_r[0])
    else $error("overflow lost");

  a_ovf_ack_clr: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_ack_only |=> !status_r[0])
    else $error("overflow not cleared by service");

  a_ovf_w1c: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    CE_I && wr_status && PWDATA_I[0] && !ev_set[`TCM_ST_OVF_BIT] |=> !status_r[0])
    else $error("overflow not cleared by write");

  a_cmp_flag_set: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    CE_I && match |=> status_r[1])
    else $error("match flag not set");

  a_ovf_no_spurious: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    CE_I && !status_r[0] && count_r != 16'hffff |=> !status_r[0])
    else $error("overflow set without wrap");

  a_irq_on: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (status_r & mask_r) != 2'h0 |-> IRQ_O)
    else $error("irq missing");

  a_irq_off: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (status_r & mask_r) == 2'h0 |-> !IRQ_O)
    else $error("irq spurious");

  a_oe_follow: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    port_r.port_dir |-> !PIN_OE_N_O)
    else $error("pin not enabled");

  a_oe_off: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    !port_r.port_dir |-> PIN_OE_N_O)
    else $error("pin enabled as input");

  a_reset_dir: assert property (@(posedge CLOCK_I)
    RST_I |=> PIN_OE_N_O)
    else $error("pin enabled after reset");

  a_reset_count: assert property (@(posedge CLOCK_I)
    RST_I |=> count_r == 16'h0000)
    else $error("count not at bottom after reset");

  a_pwm_no_force: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    wr_force && !non_pwm && !match |=> oc_r == $past(oc_r))
    else $error("force acted in pwm mode");

  a_oc_visible: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    port_r.port_dir && ctrl_r.com != TCM_COM_OFF |-> !PIN_OE_N_O && PIN_OUT_O == oc_r)
    else $error("oc not visible on pin");

endmodule // tcm_timer

// >>> tb/tcm_pin_model.sv
`timescale 1ns/10ps
// Port pad with external pull-up; floats high when not driven
module tcm_pin_model
  import tcm_pkg::*;
(
  input wire tcm_pin_t pin_i,
  output logic pad_o
);
  assign pad_o = pin_i.pin_oe_n ? 1'b1 : pin_i.pin_out;
endmodule // tcm_pin_model

// >>> tb/tb_top.sv
`timescale 1ns/10ps
`include "tcm_map.svh"
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module tb_top
  import tcm_pkg::*;
;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, ack = 0, ce = 1;
  logic [31:0] held;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, irq, pin_out, pin_oe_n, pad, err;
  int error_cnt = 0, total_checks = 0;
  logic [1:0] coms [5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
  logic ocs [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  tcm_timer tcm_timer_i (.CLOCK_I(clk), .RST_I(rst), .CE_I(ce), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .OVF_ACK_I(ack),
    .IRQ_O(irq), .PIN_OUT_O(pin_out), .PIN_OE_N_O(pin_oe_n));
  tcm_pin_model tcm_pin_model_i (.pin_i({pin_out, pin_oe_n}), .pad_o(pad));
  initial forever #2.5 clk = ~clk;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    `CHK("oe_n", 1'b1, pin_oe_n)
    xfer(0, `TCM_OFF_CMP, 0);
    `CHK("cmp", 32'h0000ffff, rd)
    xfer(0, `TCM_OFF_FORCE, 0);
    `CHK("oc", 1'b0, rd[0])
    xfer(1, `TCM_OFF_PORT, 32'h2);
    for (int i = 0; i < 5; i++) begin
      xfer(1, `TCM_OFF_CTRL, {30'h0, coms[i]});
      xfer(1, `TCM_OFF_FORCE, 32'h1);
      xfer(0, `TCM_OFF_FORCE, 0);
      `CHK("oc", ocs[i], rd[0])
      `CHK("pad", (i > 2 && coms[i] != 0) ? ocs[i] : 1'b1, pad)
      `CHK("pin", (coms[i] != 0) ? ocs[i] : 1'b1, pin_out)
      if (i == 2) xfer(1, `TCM_OFF_PORT, 32'h3);
      if (i > 2) `CHK("pad", (coms[i] != 0) ? ocs[i] : 1'b1, pad)
    end
    xfer(0, 12'h020, 0);
    `CHK("slverr", 1'b1, err)
    xfer(1, `TCM_OFF_MASK, 32'h1);
    xfer(1, `TCM_OFF_CMP, 32'h4);
    xfer(1, `TCM_OFF_COUNT, 32'hfff0);
    xfer(1, `TCM_OFF_CTRL, 32'h100);
    for (int n = 0; n < 100 && irq !== 1'b1; n++) @(posedge clk);
    `CHK("irq", 1'b1, irq)
    repeat (20) @(posedge clk);
    xfer(0, `TCM_OFF_STATUS, 0);
    `CHK("status", 2'h3, rd[1:0])
    xfer(0, `TCM_OFF_COUNT, 0);
    `CHK("count past cmp", 1'b1, rd[15:0] > 16'h4 && rd[15:0] < 16'h80)
    @(posedge clk);
    ce <= 1'b0;
    xfer(0, `TCM_OFF_COUNT, 0);
    held = rd;
    xfer(0, `TCM_OFF_COUNT, 0);
    `CHK("count frozen", held, rd)
    ce <= 1'b1;
    xfer(1, `TCM_OFF_MASK, 32'h0);
    @(posedge clk);
    `CHK("irq masked", 1'b0, irq)
    xfer(1, `TCM_OFF_MASK, 32'h1);
    @(posedge clk);
    `CHK("irq unmasked", 1'b1, irq)
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    xfer(0, `TCM_OFF_STATUS, 0);
    `CHK("ovf clr", 1'b0, rd[0])
    `CHK("irq clr", 1'b0, irq)
    conclude();
  end
endmodule // tb_top
